// >>> rtl/brg_pkg.sv
package brg_pkg;
  // Register 1 layout (8 bits): root-holdoff at 7, request at 6, gap-count 5:0.
  localparam logic [3:0] BRG_REG1_ADDR     = 4'h1;
  localparam int         BRG_RHB_POS       = 7;
  localparam int         BRG_IBR_POS       = 6;
  localparam logic [5:0] BRG_GAP_MAX       = 6'h3f;
  localparam logic [5:0] BRG_GAP_RESET     = 6'h3f;
  localparam logic       BRG_RHB_RESET     = 1'b0;
  // Request stream lengths on the pin, start and stop bits included.
  localparam int         BRG_RD_LEN        = 9;
  localparam int         BRG_WR_LEN        = 17;
  localparam logic [2:0] BRG_TYPE_READ     = 3'h5;
  localparam logic [2:0] BRG_TYPE_WRITE    = 3'h6;
  localparam logic [4:0] BRG_RESET_CYCLES  = 5'h08;

  typedef struct packed {
    logic       valid;
    logic       root_holdoff_bit;
    logic [5:0] gap;
  } brg_cfg_t;

  typedef struct packed {
    logic       root_holdoff_bit;
    logic       bus_reset_request_bit;
    logic [5:0] gap;
  } brg_reg1_t;
endpackage : brg_pkg

// >>> rtl/brg_link_request_line_rx.sv
`timescale 1ns/100ps
// Deserialises register read and write requests from the link request line.
module brg_link_request_line_rx
  import brg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       link_request_line,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic [3:0]      addr,
  output logic [7:0]      data
);
  logic [15:0] sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d;
  logic        wr_d, rd_d;

  always_comb begin
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    wr_d   = 1'b0;
    rd_d   = 1'b0;
    if (!busy_q) begin
      if (link_request_line) begin
        busy_d = 1'b1;
        cnt_d  = 5'h00;
        sh_d   = '0;
      end
    end else begin
      // The start bit is not counted, so the stop bit is the last one shifted in and a
      // start bit that follows it at once opens the next frame.
      sh_d  = {sh_q[14:0], link_request_line};
      cnt_d = cnt_q + 5'h01;
      if (cnt_d == 5'(BRG_RD_LEN - 1) && sh_d[7:5] == BRG_TYPE_READ) begin
        rd_d   = 1'b1;
        busy_d = 1'b0;
      end else if (cnt_d == 5'(BRG_WR_LEN - 1)) begin
        wr_d   = (sh_d[15:13] == BRG_TYPE_WRITE);
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q   <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      wr_stb <= wr_d;
      rd_stb <= rd_d;
    end
  end

  // Frame after start bit: type(3) addr(4) data(8) stop(1); a read has no data.
  assign addr = wr_stb ? sh_q[12:9] : sh_q[4:1];
  assign data = sh_q[8:1];
endmodule : brg_link_request_line_rx

// >>> rtl/brg_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Writing one to the request bit starts a bus reset and initialization.
// - Request, root-holdoff and gap-count share register 1; each write sets all.
// - Sent or received config packets load root-holdoff and gap-count.
// - Two bus resets without a gap-count update force gap-count to 63.
// - A reset started by a register 1 write keeps that write's gap-count.
// - After sending a config packet its values are readable in register 1.
module brg_ctrl
  import brg_pkg::*;
(
  input  wire logic           CORE_CLK,
  input  wire logic           RESET,
  input  wire logic           LINK_REQUEST_LINE,
  input  wire brg_pkg::brg_cfg_t CFG_TX,
  input  wire brg_pkg::brg_cfg_t CFG_RX,
  input  wire logic           BUS_RESET_SEEN,
  output logic                BUS_RESET_START,
  output logic                BUS_RESET_ACTIVE,
  output logic                READ_VALID,
  output logic [7:0]          READ_DATA,
  output logic                ROOT_HOLDOFF,
  output logic [5:0]          GAP_COUNT
);
  import brg_pkg::*;

  logic       link_request_line_s1_q, link_request_line_s2_q;
  logic       wr_stb, rd_stb;
  logic [3:0] rq_addr;
  logic [7:0] rq_data;
  brg_reg1_t  wdat;
  logic       reg1_wr;

  logic       rhb_q, rhb_d;
  logic [5:0] gap_q, gap_d;
  logic       upd_q, upd_d;
  logic       start_q, start_d;
  logic [4:0] rcnt_q, rcnt_d;
  logic       act_q, act_d;
  logic       rv_q, rv_d;
  logic [7:0] rdat_q, rdat_d;
  logic       reset_evt;

  // The link request pin is asynchronous to this clock.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      link_request_line_s1_q <= 1'b0;
      link_request_line_s2_q <= 1'b0;
    end else begin
      link_request_line_s1_q <= LINK_REQUEST_LINE;
      link_request_line_s2_q <= link_request_line_s1_q;
    end
  end

  brg_link_request_line_rx u_rx (
    .clk    (CORE_CLK),
    .rst    (RESET),
    .link_request_line   (link_request_line_s2_q),
    .wr_stb (wr_stb),
    .rd_stb (rd_stb),
    .addr   (rq_addr),
    .data   (rq_data)
  );

  assign wdat      = brg_reg1_t'(rq_data);
  assign reg1_wr   = wr_stb && (rq_addr == BRG_REG1_ADDR);
  assign reset_evt = BUS_RESET_SEEN || start_q;

  always_comb begin
    rhb_d   = rhb_q;
    gap_d   = gap_q;
    upd_d   = upd_q;
    start_d = 1'b0;
    rcnt_d  = (rcnt_q != 5'h00) ? rcnt_q - 5'h01 : rcnt_q;
    // A reset with no update since the previous one forces the maximum gap.
    if (reset_evt) begin
      if (!upd_q) begin
        gap_d = BRG_GAP_MAX;
      end
      upd_d = 1'b0;
    end
    // Loads come after the reset check so an update in the same cycle wins.
    if (CFG_RX.valid || CFG_TX.valid) begin
      rhb_d = CFG_TX.valid ? CFG_TX.root_holdoff_bit : CFG_RX.root_holdoff_bit;
      gap_d = CFG_TX.valid ? CFG_TX.gap : CFG_RX.gap;
      upd_d = 1'b1;
    end
    if (reg1_wr) begin
      rhb_d = wdat.root_holdoff_bit;
      gap_d = wdat.gap;
      // The write's own reset must not discard the value just loaded.
      upd_d = 1'b1;
      if (wdat.bus_reset_request_bit) begin
        start_d = 1'b1;
        rcnt_d  = BRG_RESET_CYCLES;
      end
    end
    act_d = (rcnt_d != 5'h00);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rhb_q   <= BRG_RHB_RESET;
      gap_q   <= BRG_GAP_RESET;
      upd_q   <= 1'b0;
      start_q <= 1'b0;
      rcnt_q  <= '0;
      act_q   <= 1'b0;
    end else begin
      rhb_q   <= rhb_d;
      gap_q   <= gap_d;
      upd_q   <= upd_d;
      start_q <= start_d;
      rcnt_q  <= rcnt_d;
      act_q   <= act_d;
    end
  end

  // The request bit is self-clearing and always reads back as zero.
  always_comb begin
    rv_d   = rd_stb;
    rdat_d = rdat_q;
    if (rd_stb) begin
      rdat_d = (rq_addr == BRG_REG1_ADDR) ? {rhb_q, 1'b0, gap_q} : 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rv_q   <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      rv_q   <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  assign BUS_RESET_START  = start_q;
  assign BUS_RESET_ACTIVE = act_q;
  assign READ_VALID       = rv_q;
  assign READ_DATA        = rdat_q;
  assign ROOT_HOLDOFF     = rhb_q;
  assign GAP_COUNT        = gap_q;

  ibr_start_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    reg1_wr && wdat.bus_reset_request_bit |=> BUS_RESET_START ##1 BUS_RESET_ACTIVE)
    else $error("Request bit write did not start a bus reset.");
  reg_write_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    reg1_wr |=> GAP_COUNT == $past(wdat.gap) && ROOT_HOLDOFF == $past(wdat.root_holdoff_bit))
    else $error("Register 1 write did not load both fields.");
  cfg_load_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !reg1_wr && CFG_RX.valid && !CFG_TX.valid |=> GAP_COUNT == $past(CFG_RX.gap))
    else $error("Received config packet not loaded.");
  tx_load_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !reg1_wr && CFG_TX.valid |=> GAP_COUNT == $past(CFG_TX.gap) && ROOT_HOLDOFF == $past(CFG_TX.root_holdoff_bit))
    else $error("Sent config packet not held in register 1.");
  gap_force_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    reset_evt && !upd_q && !reg1_wr && !CFG_RX.valid && !CFG_TX.valid |=> GAP_COUNT == 6'h3f)
    else $error("Gap-count not forced to 63.");
  gap_keep_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (reg1_wr && wdat.bus_reset_request_bit && !CFG_RX.valid && !CFG_TX.valid && !BUS_RESET_SEEN)
      ##1 (!reg1_wr && !CFG_RX.valid && !CFG_TX.valid) |=> GAP_COUNT == $past(wdat.gap, 2))
    else $error("Own bus reset reverted the written gap-count.");
  upd_flag_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    reset_evt && !reg1_wr && !CFG_RX.valid && !CFG_TX.valid |=> !upd_q)
    else $error("Update flag not cleared by bus reset.");
  read_back_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    rd_stb && rq_addr == BRG_REG1_ADDR |=> READ_VALID && READ_DATA[5:0] == $past(gap_q))
    else $error("Register 1 read returned wrong gap-count.");
endmodule : brg_ctrl

// >>> bench/brg_link_model.sv
`timescale 1ns/100ps
module brg_link_model
  import brg_pkg::*;
(
  input  wire logic clk,
  output logic      link_request_line
);
  initial link_request_line = 1'b0;
  // One bit per clock, start bit first; the line falls back low with the stop bit.
  task send(input logic [15:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      link_request_line <= bits[i];
    end
    @(posedge clk);
    link_request_line <= 1'b0;
  endtask : send
  task write_reg(input logic [3:0] a, input logic [7:0] d);
    send({1'b1, BRG_TYPE_WRITE, a, d}, BRG_WR_LEN - 1);
  endtask : write_reg
  task read_reg(input logic [3:0] a);
    send({8'h00, 1'b1, BRG_TYPE_READ, a}, BRG_RD_LEN - 1);
  endtask : read_reg
endmodule : brg_link_model

// >>> bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import brg_pkg::*;
  logic       clk, rst, link_request_line, seen, start, active, rvalid, rhb_o;
  logic [7:0] rdata;
  logic [5:0] gap_o;
  brg_cfg_t   cfg_tx, cfg_rx;
  int         errors, n_tests, seed, m_gap, m_rhb, m_upd, k, g;
  brg_ctrl brg_ctrl_inst(.CORE_CLK(clk), .RESET(rst), .LINK_REQUEST_LINE(link_request_line), .CFG_TX(cfg_tx),
    .CFG_RX(cfg_rx), .BUS_RESET_SEEN(seen), .BUS_RESET_START(start), .BUS_RESET_ACTIVE(active),
    .READ_VALID(rvalid), .READ_DATA(rdata), .ROOT_HOLDOFF(rhb_o), .GAP_COUNT(gap_o));
  brg_link_model brg_link_model_inst(.clk(clk), .link_request_line(link_request_line));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task results;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chk
  task stuck;
    errors++;
    results();
  endtask : stuck
  task fields;
    chk({rhb_o, 1'b0, gap_o}, 8'(m_rhb * 128 + m_gap));
  endtask : fields
  // A bus reset keeps the gap-count only when something updated it since the last one.
  task bus_evt;
    if (m_upd == 0) m_gap = 63;
    m_upd = 0;
  endtask : bus_evt
  task wr(input int root_holdoff_bit, input int gap);
    brg_link_model_inst.write_reg(4'h1, {root_holdoff_bit[0], 1'b1, gap[5:0]});
    m_rhb = root_holdoff_bit & 1;
    m_gap = gap & 63;
    m_upd = 1;
    for (k = 0; k < 40 && start !== 1'b1; k++) @(negedge clk);
    if (start !== 1'b1) stuck();
    else begin
      bus_evt();
      @(negedge clk);
      chk({7'h00, start}, 8'h00);
      for (k = 1; k < 40 && active === 1'b1; k++) @(negedge clk);
      chk(8'(k), 8'(BRG_RESET_CYCLES));
    end
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] exp);
    brg_link_model_inst.read_reg(a);
    for (k = 0; k < 20 && rvalid !== 1'b1; k++) @(negedge clk);
    if (rvalid !== 1'b1) stuck();
    else chk(rdata, exp);
  endtask : rd
  task cfg(input bit rx, input int root_holdoff_bit, input int gap);
    @(posedge clk);
    if (rx) cfg_rx <= {1'b1, root_holdoff_bit[0], gap[5:0]};
    else cfg_tx <= {1'b1, root_holdoff_bit[0], gap[5:0]};
    @(posedge clk);
    cfg_rx <= '0;
    cfg_tx <= '0;
    m_rhb = root_holdoff_bit & 1;
    m_gap = gap & 63;
    m_upd = 1;
    @(negedge clk);
  endtask : cfg
  task seen_pulse;
    @(posedge clk);
    seen <= 1'b1;
    @(posedge clk);
    seen <= 1'b0;
    bus_evt();
    @(negedge clk);
  endtask : seen_pulse
  initial begin
    seed = 66203;
    rst = 1'b1;
    seen = 1'b0;
    cfg_tx = '0;
    cfg_rx = '0;
    m_gap = 63;
    m_rhb = 0;
    m_upd = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    fields();
    $display("reset test done");
    // Random gap values reach register 1 only through config packets and their rewrite.
    for (g = 0; g < 4; g++) begin
      cfg(g[0], $random(seed), $random(seed));
      fields();
      rd(4'h1, 8'(m_rhb * 128 + m_gap));
      wr(m_rhb, m_gap);
      fields();
      rd(4'h1, 8'(m_rhb * 128 + m_gap));
      seen_pulse();
      fields();
    end
    rd(4'h9, 8'h00);
    $display("register test done");
    wr(m_rhb, 63);
    fields();
    rd(4'h1, 8'(m_rhb * 128 + m_gap));
    cfg(0, $random(seed), $random(seed));
    fields();
    rd(4'h1, 8'(m_rhb * 128 + m_gap));
    wr(m_rhb, m_gap);
    fields();
    seen_pulse();
    fields();
    cfg(1, $random(seed), $random(seed));
    fields();
    seen_pulse();
    fields();
    seen_pulse();
    fields();
    $display("config packet test done");
    results();
  end
endmodule : tb_top
